// [rtl/haptic_map.vh]
// Register offsets, field positions, reset values and timing constants
`ifndef HAPTIC_MAP_VH
`define HAPTIC_MAP_VH

// ==========================================================
// Bus address
`define TARGET_ADDR          7'h59

// ==========================================================
// Register offsets
`define REG_BUFFER_STATUS    8'h00
`define REG_SOURCE_GAIN      8'h01
`define REG_POWER_CONTROL    8'h02
`define REG_WAVEFORM_ENTRY   8'h0B

// ==========================================================
// Field positions
`define BIT_FULL             0
`define BIT_EMPTY            1
`define BIT_SOURCE           2
`define GAIN_MSB             1
`define GAIN_LSB             0
`define ID_MSB               6
`define ID_LSB               3
`define BIT_OVERRIDE         1
`define TIMEOUT_MSB          3
`define TIMEOUT_LSB          2
`define BIT_STANDBY          6
`define BIT_SOFT_RESET       7

// ==========================================================
// Reset values and masks
`define RST_SOURCE_GAIN      3'h0
`define RST_POWER_CONTROL    8'h40
`define MASK_POWER_CONTROL   8'hCE
`define PART_ID_DEFAULT      4'hA

// ==========================================================
// Timing
`define BUFFER_DEPTH         100
`define SAMPLE_RATE_HZ       8000
`define CLOCK_HZ             100000000
`define SAMPLE_CYCLES        (`CLOCK_HZ / `SAMPLE_RATE_HZ)

`endif

// [rtl/sample_fifo.v]
// Synchronous FIFO with valid and ready on both sides
module sample_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             rst,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Status
    output wire             empty,
    output wire             full
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign full      = (count == DEPTH[AW:0]);
    assign empty     = (count == {(AW+1){1'b0}});
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;

    always @(posedge mclk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
                          {AW{1'b0}} : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule // sample_fifo

// [rtl/sample_clock.v]
// Divider giving a one-cycle playback sample enable
module sample_clock #(
    parameter DIVIDE = 12500
) (
    // Clock and reset
    input  wire mclk,
    input  wire rst,
    // Enable out
    output reg  tick
);
    reg [31:0] count;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else if (count >= DIVIDE - 1) begin
            count <= 32'h0;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick  <= 1'b0;
        end
    end
endmodule // sample_clock

// [rtl/haptic_i2c_register_port.v]
// I2C target port and register bank of a haptic driver
`include "haptic_map.vh"

// Behaviour
// - Single and multi-byte access on all registers
// - Register address auto-increments until stop, except on buffer writes
// - Register byte follows address and is acknowledged
// - Every written data byte is acknowledged, except a buffer byte while full or a power byte with soft reset set
// - Read data shifted out MSB first
// - Empty flag read-only, resets to one
// - Full flag read-only, resets to zero
// - Source select bit, reset zero
// - Two-bit gain field, reset zero
// - Read-only part identifier field
// - Answer only to address 0x59
// - Refuse buffer byte while full
// - Buffer writes do not advance address
module haptic_i2c_register_port #(
    parameter PART_ID      = `PART_ID_DEFAULT,
    parameter BUFFER_DEPTH = `BUFFER_DEPTH,
    parameter BUF_AW       = 7,
    parameter STAGE_DEPTH  = 8,
    parameter SAMPLE_DIV   = `SAMPLE_CYCLES
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst,
    // Bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    // Playback side
    output reg  [7:0] sample_out,
    output reg        sample_strobe,
    output reg        source_select,
    output reg  [1:0] gain_select,
    output reg  [7:0] power_control
);
    // ==========================================================
    // Pin synchronisers and edges
    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg       scl_d;
    reg       sda_d;
    wire      scl_rise = scl_sync[1] && !scl_d;
    wire      scl_fall = !scl_sync[1] && scl_d;
    wire      start_c  = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
    wire      stop_c   = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    // ==========================================================
    // States
    localparam ST_IDLE  = 6'b000001;
    localparam ST_ADDR  = 6'b000010;
    localparam ST_REG   = 6'b000100;
    localparam ST_WDATA = 6'b001000;
    localparam ST_RDATA = 6'b010000;
    localparam ST_ACK   = 6'b100000;

    reg [5:0] state;
    reg [5:0] after_ack;
    reg [7:0] shift;
    reg [3:0] bitcnt;
    reg [7:0] reg_ptr;
    reg       ack_drive;
    reg       read_mode;
    reg       rd_acked;

    // ==========================================================
    // Buffer path: staging FIFO feeding the playback store
    wire       stage_ready;
    wire       stage_valid;
    wire [7:0] stage_data;
    wire       stage_empty;
    reg        push_req;
    reg  [7:0] push_data;
    reg  [7:0] store [0:BUFFER_DEPTH-1];
    reg  [BUF_AW-1:0] wp;
    reg  [BUF_AW-1:0] rp;
    reg  [BUF_AW:0]   level;
    wire       tick;
    wire       store_full  = (level == BUFFER_DEPTH[BUF_AW:0]);
    wire       store_empty = (level == {(BUF_AW+1){1'b0}});
    wire       drain       = stage_valid && !store_full;
    wire       play        = tick && !store_empty;
    wire       stage_full;
    wire       buf_full    = store_full && stage_full;
    wire       buf_empty   = store_empty && stage_empty;

    sample_fifo #(
        .WIDTH (8),
        .DEPTH (STAGE_DEPTH),
        .AW    (3)
    ) u_stage (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (push_req),
        .in_ready  (stage_ready),
        .in_data   (push_data),
        .out_valid (stage_valid),
        .out_ready (!store_full),
        .out_data  (stage_data),
        .empty     (stage_empty),
        .full      (stage_full)
    );

    sample_clock #(
        .DIVIDE (SAMPLE_DIV)
    ) u_tick (
        .mclk (mclk),
        .rst  (rst),
        .tick (tick)
    );

    always @(posedge mclk) begin
        if (drain)
            store[wp] <= stage_data;
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wp            <= {BUF_AW{1'b0}};
            rp            <= {BUF_AW{1'b0}};
            level         <= {(BUF_AW+1){1'b0}};
            sample_out    <= 8'h00;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= play;
            if (play)
                sample_out <= store[rp];
            if (drain)
                wp <= (wp == BUFFER_DEPTH[BUF_AW-1:0] - 1'b1) ?
                      {BUF_AW{1'b0}} : wp + 1'b1;
            if (play)
                rp <= (rp == BUFFER_DEPTH[BUF_AW-1:0] - 1'b1) ?
                      {BUF_AW{1'b0}} : rp + 1'b1;
            if (drain && !play)
                level <= level + 1'b1;
            else if (play && !drain)
                level <= level - 1'b1;
        end
    end

    // ==========================================================
    // Register read mux
    reg [7:0] rd_value;
    always @* begin
        case (reg_ptr)
            `REG_BUFFER_STATUS:
                rd_value = {6'h00, buf_empty, buf_full};
            `REG_SOURCE_GAIN:
                rd_value = {1'b0, PART_ID[3:0], source_select,
                            gain_select};
            `REG_POWER_CONTROL:
                rd_value = power_control & `MASK_POWER_CONTROL;
            default:
                rd_value = 8'h00;
        endcase
    end

    // ==========================================================
    // Bus engine
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state         <= ST_IDLE;
            after_ack     <= ST_IDLE;
            shift         <= 8'h00;
            bitcnt        <= 4'h0;
            reg_ptr       <= 8'h00;
            ack_drive     <= 1'b0;
            read_mode     <= 1'b0;
            rd_acked      <= 1'b0;
            sda_out       <= 1'b0;
            sda_oe        <= 1'b0;
            push_req      <= 1'b0;
            push_data     <= 8'h00;
            source_select <= 1'b0;
            gain_select   <= 2'b00;
            power_control <= `RST_POWER_CONTROL;
        end else begin
            push_req <= 1'b0;
            sda_out  <= 1'b0;
            if (power_control[`BIT_SOFT_RESET]) begin
                source_select <= 1'b0;
                gain_select   <= 2'b00;
                power_control <= `RST_POWER_CONTROL;
                state         <= ST_IDLE;
                sda_oe        <= 1'b0;
            end else if (start_c) begin
                state  <= ST_ADDR;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        if (scl_rise) begin
                            shift  <= {shift[6:0], sda_sync[1]};
                            bitcnt <= bitcnt + 4'h1;
                        end
                        if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt    <= 4'h0;
                            ack_drive <= 1'b1;
                            after_ack <= ST_IDLE;
                            state     <= ST_ACK;
                            sda_oe    <= 1'b1;
                            if (state == ST_ADDR) begin
                                if (shift[7:1] == `TARGET_ADDR) begin
                                    read_mode <= shift[0];
                                    after_ack <= shift[0] ? ST_RDATA
                                                          : ST_REG;
                                end else begin
                                    sda_oe <= 1'b0;
                                    state  <= ST_IDLE;
                                end
                            end else if (state == ST_REG) begin
                                reg_ptr   <= shift;
                                after_ack <= ST_WDATA;
                            end else begin
                                after_ack <= ST_WDATA;
                                if (reg_ptr == `REG_WAVEFORM_ENTRY) begin
                                    if (stage_ready) begin
                                        push_req  <= 1'b1;
                                        push_data <= shift;
                                    end else begin
                                        sda_oe    <= 1'b0;
                                        ack_drive <= 1'b0;
                                        after_ack <= ST_IDLE;
                                    end
                                end else begin
                                    reg_ptr <= reg_ptr + 8'h01;
                                    if (reg_ptr == `REG_SOURCE_GAIN) begin
                                        source_select <=
                                            shift[`BIT_SOURCE];
                                        gain_select <=
                                            shift[`GAIN_MSB:`GAIN_LSB];
                                    end
                                    if (reg_ptr == `REG_POWER_CONTROL)
                                        power_control <= shift &
                                            `MASK_POWER_CONTROL;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            state  <= after_ack;
                            sda_oe <= 1'b0;
                            if (after_ack == ST_RDATA) begin
                                shift  <= rd_value;
                                sda_oe <= !rd_value[7];
                                bitcnt <= 4'h1;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_rise && bitcnt == 4'h9)
                            rd_acked <= !sda_sync[1];
                        if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                sda_oe  <= 1'b0;
                                bitcnt  <= 4'h9;
                                reg_ptr <= reg_ptr + 8'h01;
                            end else if (bitcnt == 4'h9) begin
                                if (rd_acked) begin
                                    shift  <= rd_value;
                                    sda_oe <= !rd_value[7];
                                    bitcnt <= 4'h1;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                shift  <= {shift[6:0], 1'b0};
                                sda_oe <= !shift[6];
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // haptic_i2c_register_port

// [testbench/haptic_port_assertions.sv]
// Concurrent checks on the haptic register port pins
module haptic_port_checker (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // Bus pins
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    // Playback side
    input wire logic [7:0] sample_out,
    input wire logic       sample_strobe,
    input wire logic       source_select,
    input wire logic [1:0] gain_select,
    input wire logic [7:0] power_control
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Assertions
    a_sda_open_drain: assert property (sda_oe |-> !sda_out)
        else $error("sda driven high");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda changed while scl high");
    a_ack_holds: assert property (
        $fell(scl_in) && sda_oe |=> sda_oe[*2])
        else $error("sda released too early");
    a_config_reset: assert property (
        $fell(rst) |-> !source_select && gain_select == 2'h0
        && power_control == 8'h40)
        else $error("config not at reset value");
    a_power_reserved: assert property (
        (power_control & 8'h31) == 8'h00)
        else $error("reserved power bits set");
    a_gain_timing: assert property (
        $changed(gain_select) |-> !scl_in && !$past(scl_in, 2))
        else $error("gain changed outside scl low");
    a_source_timing: assert property (
        $changed(source_select) |-> !scl_in && !$past(scl_in, 2))
        else $error("source changed outside scl low");
    a_strobe_spaced: assert property (
        sample_strobe |=> !sample_strobe[*8])
        else $error("sample strobe too long");

    // ==========================================================
    // Cover
    c_ack: cover property ($rose(sda_oe));
    c_gain: cover property ($changed(gain_select));
    c_play: cover property (sample_strobe);
endmodule // haptic_port_checker

bind haptic_i2c_register_port haptic_port_checker chk (
    .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .sample_out(sample_out),
    .sample_strobe(sample_strobe), .source_select(source_select),
    .gain_select(gain_select), .power_control(power_control)
);

// [testbench/i2c_host_model.sv]
// Bus host model driving SCL and pulling SDA low
module i2c_host_model (
    // Clock
    input  wire logic mclk,
    // Bus
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // ==========================================================
    // Start and repeated start
    task automatic start_c();
        sda_low = 1'b0;
        wait_n(3);
        scl = 1'b1;
        wait_n(6);
        sda_low = 1'b1;
        wait_n(6);
        scl = 1'b0;
        wait_n(3);
    endtask

    // Stop after last byte
    task automatic stop_c();
        sda_low = 1'b1;
        wait_n(3);
        scl = 1'b1;
        wait_n(6);
        sda_low = 1'b0;
        wait_n(6);
    endtask

    // One clock: 7 low, 6 high
    task automatic bit_c(input logic b, output logic s);
        sda_low = !b;
        wait_n(4);
        scl = 1'b1;
        wait_n(3);
        s = sda_line;
        wait_n(3);
        scl = 1'b0;
        wait_n(3);
    endtask

    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], s);
        end
        bit_c(1'b1, s);
        ack = !s;
    endtask

    task automatic recv(output logic [7:0] d, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, d[i]);
        end
        bit_c(!ack, s);
    endtask
endmodule // i2c_host_model

// [testbench/testbench.sv]
// Self-checking bench for the haptic register port
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [3:0] ID = 4'h6; // Arbitrary part identifier
    localparam int FILL = 100 + 8;
    localparam logic [6:0] DEV = 7'h59;

    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       scl;
    logic       sda_low;
    logic       sda_line;
    logic       sda_out;
    logic       sda_oe;
    logic [7:0] sample_out;
    logic       sample_strobe;
    logic       source_select;
    logic [1:0] gain_select;
    logic [7:0] power_control;
    logic [7:0] wdat [0:127];
    logic [7:0] rdat [0:7];
    int         err_count = 0;
    int         n_tests = 0;
    int         acked;

    always #5 mclk = ~mclk;
    assign sda_line = !sda_low && !(sda_oe && !sda_out);

    // ==========================================================
    // Instances
    haptic_i2c_register_port #(.PART_ID(ID), .SAMPLE_DIV(50000)) DUT (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .sample_out(sample_out),
        .sample_strobe(sample_strobe), .source_select(source_select),
        .gain_select(gain_select), .power_control(power_control)
    );
    i2c_host_model host (
        .mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
    );

    // ==========================================================
    // Tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Write n bytes from wdat, stop at first refusal
    task automatic wr(input logic [6:0] dv, input logic [7:0] ra,
                      input int n);
        logic a;
        acked = -1;
        host.start_c();
        host.send({dv, 1'b0}, a);
        if (a) begin
            host.send(ra, a);
            acked = 0;
            for (int i = 0; i < n && a; i++) begin
                host.send(wdat[i], a);
                if (a) acked++;
            end
        end
        host.stop_c();
    endtask

    task automatic rd(input logic [7:0] ra, input int n);
        logic a;
        host.start_c();
        host.send({DEV, 1'b0}, a);
        host.send(ra, a);
        host.start_c();
        host.send({DEV, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            host.recv(rdat[i], i < n - 1);
        end
        host.stop_c();
    endtask

    // ==========================================================
    // Sequence
    initial begin
        logic [1:0] c;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        repeat (5) @(negedge mclk);
        rd(8'h00, 3);
        check(rdat[0], 8'h02);
        check(rdat[1], {1'b0, ID, 3'h0});
        check(rdat[2], 8'h40);
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            wdat[0] = {5'h1F, c[0], c};
            wr(DEV, 8'h01, 1);
            check(8'(acked), 8'h01);
            check({6'h0, gain_select}, {6'h0, c});
            check({7'h0, source_select}, {7'h0, c[0]});
            rd(8'h01, 1);
            check(rdat[0], {1'b0, ID, c[0], c});
        end
        wdat[0] = 8'h02;
        wdat[1] = 8'h7E;
        wr(DEV, 8'h01, 2);
        check(8'(acked), 8'h02);
        check(power_control, 8'h4E);
        check({6'h0, gain_select}, 8'h02);
        wdat[0] = 8'hFF;
        wr(DEV, 8'h00, 1);
        rd(8'h00, 1);
        check(rdat[0], 8'h02);
        wdat[0] = 8'h01;
        wr(7'h58, 8'h01, 1);
        check(8'(acked), 8'hFF);
        check({6'h0, gain_select}, 8'h02);
        // Buffer fill until refused
        for (int i = 0; i < 120; i++) begin
            wdat[i] = 8'(8'h10 + i);
        end
        wr(DEV, 8'h0B, 120);
        check(8'(acked), 8'(FILL));
        check(power_control, 8'h4E);
        rd(8'h00, 1);
        check(rdat[0], 8'h01);
        for (int t = 0; sample_strobe !== 1'b1; t++) begin
            if (t == 60000) begin
                err_count++;
                break;
            end
            @(negedge mclk);
        end
        check(sample_out, 8'h10);
        rd(8'h00, 1);
        check(rdat[0], 8'h00);
        wdat[0] = 8'(8'h10 + FILL);
        wr(DEV, 8'h0B, 1);
        check(8'(acked), 8'h01);
        // Soft reset restores the configuration registers
        wdat[0] = 8'h80;
        wr(DEV, 8'h02, 1);
        check(power_control, 8'h40);
        check({6'h0, gain_select}, 8'h00);
        conclude();
    end
endmodule // testbench
